//--- hw/eeprom_link_pkg.sv
package eeprom_link_pkg;
	// Opcodes (configurable, values arbitrary)
	localparam logic [7:0] OP_SIGNATURE  = 8'hAB;
	localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
	localparam logic [7:0] OP_WRITE_EN   = 8'h06;
	localparam logic [7:0] OP_WRITE_SR   = 8'h01;
	localparam logic [7:0] OP_WRITE_DATA = 8'h02;
	// Signature value, arbitrary
	localparam logic [7:0] SIGNATURE_VAL = 8'h5A;
	localparam int         INSTR_BITS    = 8;
	localparam int         ADDR_BITS     = 16;
	localparam int         SIG_BITS      = 8;
	localparam int         SR_PROT_BIT   = 7;
	localparam logic [7:0] SR_RESET      = 8'h00;
	// Release delay in ns and derived cycles at 4 ns
	localparam int         CLK_PERIOD_NS = 4;
	localparam int         RELEASE_NS    = 400;
	localparam int         RELEASE_CYC   = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         PROG_NS       = 2000;
	localparam int         PROG_CYC      = (PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] RELEASE_CNT  = 16'(RELEASE_CYC);
	localparam logic [15:0] PROG_CNT     = 16'(PROG_CYC);
	localparam logic [15:0] CNT_ONE      = 16'h0001;
	localparam logic [15:0] CNT_ZERO     = 16'h0000;
	// Master clock half period minus one, in system cycles
	localparam logic [3:0]  HALF_DIV     = 4'h6;
	localparam logic [5:0]  BIT_ZERO     = 6'h00;
	localparam logic [5:0]  BIT_INSTR    = 6'h08;
	localparam logic [5:0]  BIT_ADDR_END = 6'h18;
	localparam logic [5:0]  BIT_DATA_END = 6'h20;
endpackage

//--- hw/eeprom_link_if.sv
interface eeprom_link_if;
	logic sel_n;
	logic sclk;
	logic sdi;
	logic pause_n;
	logic sdo_o;
	logic sdo_oe;
	logic sdo;
	// Wire level of the shared output line, pulled high when released
	assign sdo = sdo_oe ? sdo_o : 1'b1;
	modport master (output sel_n, output sclk, output sdi, output pause_n, input sdo);
	modport memory (input sel_n, input sclk, input sdi, input pause_n,
		output sdo_o, output sdo_oe);
endinterface

//--- hw/eeprom_front_end.sv
// Notes on behaviour
// - Power-down discards all but signature command
// - Signature refused while programming
// - Instruction, 16 dummy bits, 8-bit signature
// - Signature repeats until deselect
// - Deselect after signature: standby after delay
// - Deselect after instruction still releases power-down
// - Select low selects; high forces standby
// - Programming completes regardless of select
// - Output released while deselected
// - Select rise after write sequence starts program
// - Master selects before any command
// - Output changes after clock falling edge
// - Input sampled on clock rising edge
// - Protect pin low and enable bit block status
// - Enable bit low ignores protect pin
// - Protect pin change cannot stop running cycle
// - Pause holds sequence without reset
// - Pause starts at once only with clock low
// - Resume at once only with clock low
// - Clock and input ignored while paused
// - Output follows pause pin edges immediately
// - Power-down needs deselect right after instruction
module eeprom_front_end
	import eeprom_link_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	eeprom_link_if.memory link,
	input  wire logic protect_n,
	output logic      powered_down,
	output logic      programming,
	output logic [7:0] status_q
);
	logic [1:0]  sel_s;
	logic [1:0]  clk_s;
	logic [1:0]  sdi_s;
	logic [1:0]  pause_s;
	logic [1:0]  prot_s;
	logic        sclk_prev_q;
	logic        sel_prev_q;
	logic [5:0]  bit_cnt_q;
	logic [7:0]  instr_q;
	logic [7:0]  data_q;
	logic [7:0]  sig_sh_q;
	logic [2:0]  sig_idx_q;
	logic        wen_q;
	logic        paused_q;
	logic        sdo_o_q;
	logic        sdo_oe_q;
	logic        sdo_drive_q;
	logic [15:0] rel_cnt_q;
	logic [15:0] prog_cnt_q;
	logic        sig_seen_q;

	// Two-stage synchronisers on every pin
	always_ff @(posedge clk) begin
		if (srst) begin
			sel_s <= 2'b11;
			clk_s <= 2'b00;
			sdi_s <= 2'b00;
			pause_s <= 2'b11;
		end else begin
			sel_s <= {sel_s[0], link.sel_n};
			clk_s <= {clk_s[0], link.sclk};
			sdi_s <= {sdi_s[0], link.sdi};
			pause_s <= {pause_s[0], link.pause_n};
		end
	end

	wire selected = !sel_s[1] && rel_cnt_q == CNT_ZERO;
	wire rise     = clk_s[1] && !sclk_prev_q;
	wire fall     = !clk_s[1] && sclk_prev_q;
	wire sel_rise = sel_s[1] && !sel_prev_q;
	wire shift_en = selected && !paused_q;

	// Protect pin synchroniser; idle high means unprotected
	always_ff @(posedge clk) begin
		if (srst)
			prot_s <= 2'b11;
		else
			prot_s <= {prot_s[0], protect_n};
	end

	// Edge history
	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= clk_s[1];
			sel_prev_q <= sel_s[1];
		end
	end

	// Pause entry and exit only with clock low or on its falling edge
	always_ff @(posedge clk) begin
		if (srst || !selected) begin
			paused_q <= 1'b0;
		end else if (pause_s[1] != !paused_q && (!clk_s[1] || fall)) begin
			paused_q <= !pause_s[1];
		end
	end

	// Input shift on rising edge, MSB first
	always_ff @(posedge clk) begin
		if (srst || !selected) begin
			bit_cnt_q <= BIT_ZERO;
			instr_q <= 8'h00;
			data_q <= 8'h00;
		end else if (shift_en && rise) begin
			if (bit_cnt_q < BIT_INSTR)
				instr_q <= {instr_q[6:0], sdi_s[1]};
			else
				data_q <= {data_q[6:0], sdi_s[1]};
			if (!(&bit_cnt_q)) // Saturate so long frames cannot wrap
				bit_cnt_q <= bit_cnt_q + 6'h01;
		end
	end

	wire instr_done = bit_cnt_q >= BIT_INSTR;
	wire sig_cmd    = instr_done && instr_q == OP_SIGNATURE;
	wire sig_ok     = sig_cmd && !programming;
	wire sig_phase  = sig_ok && bit_cnt_q >= BIT_ADDR_END;

	// Signature shifter: loaded while deselected and after every eighth bit, shifted from address end on falling edge
	always_ff @(posedge clk) begin
		if (srst || !selected) begin
			sig_idx_q <= 3'h0;
			sig_sh_q <= SIGNATURE_VAL;
			sdo_o_q <= 1'b0;
			sig_seen_q <= 1'b0;
		end else if (shift_en && fall && sig_phase) begin
			sdo_o_q <= sig_sh_q[7];
			sig_sh_q <= (sig_idx_q == 3'h7) ? SIGNATURE_VAL : {sig_sh_q[6:0], 1'b0};
			sig_idx_q <= sig_idx_q + 3'h1;
			if (sig_idx_q == 3'h7)
				sig_seen_q <= 1'b1;
		end
	end

	// Output enable: deselect and pause release the line at once
	always_ff @(posedge clk) begin
		if (srst) begin
			sdo_drive_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			if (!selected)
				sdo_drive_q <= 1'b0;
			else if (shift_en && fall && sig_phase)
				sdo_drive_q <= 1'b1;
			sdo_oe_q <= selected && sdo_drive_q && pause_s[1];
		end
	end
	assign link.sdo_o = sdo_o_q;
	assign link.sdo_oe = sdo_oe_q;

	// Capture per-frame intents at deselect edge
	wire at_instr_end = bit_cnt_q == BIT_INSTR;
	wire sr_ok = !(status_q[SR_PROT_BIT] && !prot_s[1]);
	always_ff @(posedge clk) begin
		if (srst) begin
			wen_q <= 1'b0;
			powered_down <= 1'b0;
			status_q <= SR_RESET;
			rel_cnt_q <= CNT_ZERO;
			prog_cnt_q <= CNT_ZERO;
			programming <= 1'b0;
		end else begin
			if (rel_cnt_q != CNT_ZERO)
				rel_cnt_q <= rel_cnt_q - CNT_ONE;
			if (programming) begin
				prog_cnt_q <= prog_cnt_q - CNT_ONE;
				if (prog_cnt_q == CNT_ONE)
					programming <= 1'b0;
			end
			if (sel_rise && rel_cnt_q == CNT_ZERO) begin
				if (powered_down) begin
					if (sig_cmd && instr_done) begin
						powered_down <= 1'b0;
						rel_cnt_q <= RELEASE_CNT;
					end
				end else if (!programming) begin
					if (sig_ok && sig_seen_q)
						rel_cnt_q <= RELEASE_CNT;
					else if (at_instr_end && instr_q == OP_POWER_DOWN)
						powered_down <= 1'b1;
					else if (at_instr_end && instr_q == OP_WRITE_EN)
						wen_q <= 1'b1;
					else if (wen_q && bit_cnt_q == BIT_INSTR + BIT_INSTR // Opcode and one byte
						&& instr_q == OP_WRITE_SR) begin
						wen_q <= 1'b0;
						if (sr_ok) begin
							status_q <= data_q;
							programming <= 1'b1;
							prog_cnt_q <= PROG_CNT;
						end
					end else if (wen_q && bit_cnt_q == BIT_DATA_END
						&& instr_q == OP_WRITE_DATA) begin
						wen_q <= 1'b0;
						programming <= 1'b1;
						prog_cnt_q <= PROG_CNT;
					end
				end
			end
		end
	end
endmodule

//--- hw/eeprom_bus_master.sv
module eeprom_bus_master
	import eeprom_link_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	eeprom_link_if.master link,
	input  wire logic        start,
	input  wire logic [5:0]  nbits,
	input  wire logic [31:0] tx_word,
	input  wire logic        hold_req,
	output logic             busy,
	output logic [7:0]       rx_byte
);
	logic [3:0]  div_q;
	logic [5:0]  left_q;
	logic [31:0] sh_q;
	logic        sclk_q, sel_n_q, pause_n_q;
	logic [1:0]  sdo_s;

	// Input synchroniser
	always_ff @(posedge clk) begin
		if (srst)
			sdo_s <= 2'b11;
		else
			sdo_s <= {sdo_s[0], link.sdo};
	end

	wire tick = div_q == HALF_DIV;
	// Frame engine, MSB first; select driven low first
	always_ff @(posedge clk) begin
		if (srst) begin
			div_q <= 4'h0;
			left_q <= BIT_ZERO;
			sh_q <= 32'h0000_0000;
			sclk_q <= 1'b0;
			sel_n_q <= 1'b1;
			pause_n_q <= 1'b1;
			busy <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			div_q <= tick ? 4'h0 : div_q + 4'h1;
			if (!busy && start) begin
				busy <= 1'b1;
				sel_n_q <= 1'b0;
				left_q <= nbits;
				sh_q <= tx_word;
			end else if (busy && tick && !sclk_q) begin
				pause_n_q <= !hold_req; // changed only with clock low
				if (!hold_req && pause_n_q) begin // no clock edge on resume tick
					if (left_q == BIT_ZERO) begin
						sel_n_q <= 1'b1; // select kept low through pause
						busy <= 1'b0;
					end else
						sclk_q <= 1'b1;
				end
			end else if (busy && tick && sclk_q) begin
				sclk_q <= 1'b0;
				sh_q <= {sh_q[30:0], 1'b0};
				rx_byte <= {rx_byte[6:0], sdo_s[1]};
				left_q <= left_q - 6'h01;
			end
		end
	end
	assign link.sclk = sclk_q;
	assign link.sel_n = sel_n_q;
	assign link.pause_n = pause_n_q;
	assign link.sdi = sh_q[31];
endmodule

//--- sim/eeprom_link_chk.sv
module eeprom_link_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic pause_n,
	input wire logic sdo_o,
	input wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// Output line is released while deselected or paused
	a_released_idle: assert property (sel_n [*4] |-> !sdo_oe)
		else $error("output driven while deselected");
	a_pause_floats: assert property (!pause_n [*4] |-> !sdo_oe)
		else $error("output driven while paused");
	// Output only moves after a falling clock edge
	a_out_steady: assert property ((sdo_oe && sclk) [*6] |-> $stable(sdo_o))
		else $error("output changed while clock high");
	// Master clock rests while deselected
	a_sclk_idle: assert property (sel_n && $past(sel_n) |-> !sclk)
		else $error("clock moved while deselected");
	// Clock high and low phases last at least seven cycles
	a_sclk_high_len: assert property ($rose(sclk) |-> sclk [*7])
		else $error("clock high phase too short");
	a_sclk_low_len: assert property ($fell(sclk) |-> !sclk [*7])
		else $error("clock low phase too short");
	// Input data held while the clock stays high
	a_sdi_steady: assert property (sclk && $past(sclk) |-> $stable(sdi))
		else $error("input data changed while clock high");
	// Pause only while selected
	a_pause_selected: assert property (!pause_n |-> !sel_n)
		else $error("paused while deselected");
endmodule

//--- sim/serial_eeprom_bus_front_end_test.sv
module serial_eeprom_bus_front_end_test;
	import eeprom_link_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, srst, start, hold_req, protect_n, busy, powered_down, programming;
	logic [5:0]  nbits;
	logic [31:0] tx_word;
	logic [7:0]  rx_byte, status_q;
	int          n_mismatch, compares;

	eeprom_link_if eeprom_link_if_i ();
	eeprom_front_end eeprom_front_end_i (.clk(clk), .srst(srst), .link(eeprom_link_if_i),
		.protect_n(protect_n), .powered_down(powered_down), .programming(programming),
		.status_q(status_q));
	eeprom_bus_master eeprom_bus_master_i (.clk(clk), .srst(srst), .link(eeprom_link_if_i),
		.start(start), .nbits(nbits), .tx_word(tx_word), .hold_req(hold_req), .busy(busy),
		.rx_byte(rx_byte));
	eeprom_link_chk eeprom_link_chk_i (.clk(clk), .srst(srst), .sel_n(eeprom_link_if_i.sel_n),
		.sclk(eeprom_link_if_i.sclk), .sdi(eeprom_link_if_i.sdi),
		.pause_n(eeprom_link_if_i.pause_n), .sdo_o(eeprom_link_if_i.sdo_o),
		.sdo_oe(eeprom_link_if_i.sdo_oe));

	// Clock at 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One frame, optional pause window, then room for the release delay
	task frame(input logic [5:0] n, input logic [31:0] w, input int hold_at);
		int k;
		@(negedge clk);
		start = 1'b1;
		nbits = n;
		tx_word = w;
		@(negedge clk);
		start = 1'b0;
		k = 0;
		while (busy !== 1'b0 && k < 3000) begin
			@(negedge clk);
			k++;
			hold_req = (k >= hold_at && k < hold_at + 60);
			if (k == hold_at - 2) check("driving oe", eeprom_link_if_i.sdo_oe, 8'h01);
			if (k == hold_at + 30) check("paused oe", eeprom_link_if_i.sdo_oe, 8'h00);
			if (k == hold_at + 90) check("resumed oe", eeprom_link_if_i.sdo_oe, 8'h01);
		end
		hold_req = 1'b0;
		if (k >= 3000) check("frame end", 8'h00, 8'h01);
		repeat (RELEASE_CYC + 20) @(negedge clk);
	endtask

	task wr_status(input logic [7:0] v);
		frame(6'h08, {OP_WRITE_EN, 24'h00_0000}, 9999);
		frame(6'h10, {OP_WRITE_SR, v, 16'h0000}, 9999);
	endtask

	task wait_prog;
		int k;
		k = 0;
		while (programming !== 1'b0 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 2000) check("program end", 8'h00, 8'h01);
	endtask

	task finish_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog against a hung frame, about twice the expected run
	initial begin
		#60_000;
		n_mismatch++;
		finish_test;
	end

	initial begin
		srst = 1'b1;
		start = 1'b0;
		nbits = 6'h00;
		tx_word = 32'h0000_0000;
		hold_req = 1'b0;
		protect_n = 1'b1;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		check("reset oe", eeprom_link_if_i.sdo_oe, 8'h00);
		frame(6'h20, {OP_SIGNATURE, 24'h00_0000}, 9999);
		check("signature", rx_byte, SIGNATURE_VAL);
		frame(6'h28, {OP_SIGNATURE, 24'h00_0000}, 400);
		check("repeat after pause", rx_byte, SIGNATURE_VAL);
		$display("test signature done");
		frame(6'h08, {OP_POWER_DOWN, 24'h00_0000}, 9999);
		check("power down", {7'h00, powered_down}, 8'h01);
		frame(6'h08, {OP_WRITE_EN, 24'h00_0000}, 9999);
		check("still down", {7'h00, powered_down}, 8'h01);
		frame(6'h08, {OP_SIGNATURE, 24'h00_0000}, 9999);
		check("released", {7'h00, powered_down}, 8'h00);
		$display("test power down done");
		frame(6'h08, {OP_WRITE_EN, 24'h00_0000}, 9999);
		frame(6'h20, {OP_WRITE_DATA, 24'h12_3456}, 9999);
		check("data program", {7'h00, programming}, 8'h01);
		wait_prog;
		frame(6'h20, {OP_WRITE_DATA, 24'h12_3456}, 9999);
		check("data needs enable", {7'h00, programming}, 8'h00);
		$display("test write done");
		protect_n = 1'b0;
		wr_status(8'h80);
		check("program start", {7'h00, programming}, 8'h01);
		wait_prog;
		check("status pin ignored", status_q, 8'h80);
		wr_status(8'h00);
		wait_prog;
		check("status protected", status_q, 8'h80);
		protect_n = 1'b1;
		wr_status(8'h00);
		protect_n = 1'b0;
		wait_prog;
		check("pin fall mid cycle", status_q, 8'h00);
		$display("test protect done");
		finish_test;
	end
endmodule
